// file: hdl/ct16_timer.sv
// How it works
// - Timer count advances once every divider limit plus one clocks while running.
// - Divider at limit: next clock increments timer count, clears divider.
// - Divider count is readable and writable by software.
// - Control register can halt counting or hold counters cleared.
// - Four compares: on equality reset count, stop counters, and/or flag.
// - Per-compare enables choose interrupt flag and count reset.
// - Software picks capture edges per input and capture interrupt.
// - Selected capture edge copies timer count into read-only capture register.
// - Pending sources read as flags; software write clears them.
// - External output setup register drives match pins on compare.
// - Timer mode counts clocks; counter mode counts chosen input edges.
// - Pulse mode enable switches individual match pins into PWM.
// - All implemented register bits read zero after reset.
// - Timer count wraps from maximum to zero without raising a flag.
// - Clear bit holds both counters at zero until released.
// - Writing one clears a flag; writing zero leaves it.
// - Run bit enables both counters when one, halts when zero.
`timescale 1ns/1ps
`default_nettype none
`include "ct16_regs.svh"
module ct16_timer (
   // Clock, reset, enable
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic              ce,
   // Register port
   input  wire ct16_pkg::ct16_req_t req,
   output var  logic [31:0]       rdata,
   // Pins
   input  wire logic              capture_input_0,
   input  wire logic              capture_input_1,
   output var  logic [1:0]        match_output_pins
);
   import ct16_pkg::*;

   // ****************************************
   // State
   // ****************************************
   logic [5:0]  flags_reg;
   logic [1:0]  ctl_reg;
   logic [15:0] tc_reg;
   logic [15:0] lim_reg;
   logic [15:0] pc_reg;
   logic [11:0] mcr_reg;
   logic [15:0] mr_reg [4];
   logic [5:0]  ccr_reg;
   logic [15:0] cap_reg [2];
   logic [11:0] emr_reg;
   logic [3:0]  count_source_select_reg;
   logic [1:0]  pwm_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  pins_reg;
   logic [1:0]  cap_s1;
   logic [1:0]  cap_s2;
   logic [1:0]  cap_s3;

   function automatic logic hit(input ct16_req_t r, input logic [6:0] off);
      hit = r.wr && (r.addr == off);
   endfunction

   function automatic logic act(input logic st, input ct16_act_t a);
      unique case (a)
         CT16_KEEP:   act = st;
         CT16_LOW:    act = 1'b0;
         CT16_HIGH:   act = 1'b1;
         CT16_TOGGLE: act = ~st;
      endcase
   endfunction

   // ****************************************
   // Decode
   // ****************************************
   wire        w_flags = hit(req, `CT16_OFF_FLAGS);
   wire        w_ctl   = hit(req, `CT16_OFF_CTL);
   wire        w_tc    = hit(req, `CT16_OFF_TC);
   wire        w_lim   = hit(req, `CT16_OFF_LIM);
   wire        w_pc    = hit(req, `CT16_OFF_PC);
   wire        w_mcr   = hit(req, `CT16_OFF_MCR);
   wire        w_ccr   = hit(req, `CT16_OFF_CCR);
   wire        w_emr   = hit(req, `CT16_OFF_EMR);
   wire        w_count_source_select  = hit(req, `CT16_OFF_COUNT_SOURCE_SELECT);
   wire        w_pwm   = hit(req, `CT16_OFF_PWM);
   wire [3:0]  w_mr    = {hit(req, `CT16_OFF_MR3), hit(req, `CT16_OFF_MR2),
                          hit(req, `CT16_OFF_MR1), hit(req, `CT16_OFF_MR0)};

   // ****************************************
   // Capture edges and count source
   // ****************************************
   // Third stage feeds edge detect so the first stage is read by nothing else
   wire [1:0]  rise    = cap_s2 & ~cap_s3;
   wire [1:0]  fall    = ~cap_s2 & cap_s3;
   wire [1:0]  cap_ev;
   assign cap_ev[0] = (ccr_reg[`CT16_CCR_RISE] & rise[0])
                    | (ccr_reg[`CT16_CCR_FALL] & fall[0]);
   assign cap_ev[1] = (ccr_reg[3+`CT16_CCR_RISE] & rise[1])
                    | (ccr_reg[3+`CT16_CCR_FALL] & fall[1]);
   wire        sel     = count_source_select_reg[`CT16_COUNT_SOURCE_SELECT_SEL];
   wire        s_rise  = sel ? rise[1] : rise[0];
   wire        s_fall  = sel ? fall[1] : fall[0];
   ct16_mode_t mode;
   assign mode = ct16_mode_t'(count_source_select_reg[1:0]);
   wire        step    = (mode == CT16_TIMER)
                       | ((mode == CT16_RISE) & s_rise)
                       | ((mode == CT16_FALL) & s_fall)
                       | ((mode == CT16_BOTH) & (s_rise | s_fall));

   // ****************************************
   // Counting and compares
   // ****************************************
   wire        clr     = ctl_reg[`CT16_CTL_CLR];
   wire        adv     = ctl_reg[`CT16_CTL_RUN] & ~clr & step;
   wire        term    = adv & (pc_reg == lim_reg);
   wire [3:0]  match;
   wire [3:0]  en_int;
   wire [3:0]  en_rst;
   wire [3:0]  en_stop;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cmp
         assign match[gi]   = term & (tc_reg == mr_reg[gi]);
         assign en_int[gi]  = mcr_reg[3*gi+`CT16_MCR_INT];
         assign en_rst[gi]  = mcr_reg[3*gi+`CT16_MCR_RST];
         assign en_stop[gi] = mcr_reg[3*gi+`CT16_MCR_STOP];
      end
   endgenerate
   wire        do_rst  = |(match & en_rst);
   wire        do_stop = |(match & en_stop);
   wire [5:0]  fl_set  = {cap_ev & {ccr_reg[3+`CT16_CCR_INT], ccr_reg[`CT16_CCR_INT]},
                          match & en_int};
   wire [5:0]  fl_clr  = w_flags ? req.wdata[5:0] : 6'h00;

   // Software writes beat counting; the clear bit beats both
   logic [15:0] pc_next;
   logic [15:0] tc_next;
   logic [1:0]  ctl_next;
   logic [5:0]  flags_next;
   assign pc_next  = clr ? 16'h0000 : w_pc ? req.wdata[15:0]
                   : term ? 16'h0000 : adv ? pc_reg + 16'h0001 : pc_reg;
   assign tc_next  = clr ? 16'h0000 : w_tc ? req.wdata[15:0]
                   : !term ? tc_reg : do_rst ? 16'h0000
                   : do_stop ? tc_reg : tc_reg + 16'h0001;
   assign ctl_next = (w_ctl ? req.wdata[1:0] : ctl_reg)
                   & {1'b1, ~do_stop};
   // A flag raised in the cycle it is cleared stays set
   assign flags_next = (flags_reg & ~fl_clr) | fl_set;

   logic [11:0] emr_next;
   logic [1:0]  pins_next;
   always_comb begin
      emr_next = w_emr ? req.wdata[11:0] : emr_reg;
      for (int i = 0; i < 4; i++) begin
         if (match[i]) begin
            emr_next[i] = act(emr_reg[i],
               ct16_act_t'(emr_reg[`CT16_EMR_ACT+2*i +: 2]));
         end
      end
      for (int i = 0; i < 2; i++) begin
         // Single edge PWM: low until the count reaches the compare value
         pins_next[i] = pwm_reg[i] ? (tc_reg >= mr_reg[i]) : emr_reg[i];
      end
   end

   // ****************************************
   // Read mux
   // ****************************************
   logic [31:0] rd_next;
   always_comb begin
      unique case (req.addr)
         `CT16_OFF_FLAGS: rd_next = {26'h0, flags_reg};
         `CT16_OFF_CTL:   rd_next = {30'h0, ctl_reg};
         `CT16_OFF_TC:    rd_next = {16'h0, tc_reg};
         `CT16_OFF_LIM:   rd_next = {16'h0, lim_reg};
         `CT16_OFF_PC:    rd_next = {16'h0, pc_reg};
         `CT16_OFF_MCR:   rd_next = {20'h0, mcr_reg};
         `CT16_OFF_MR0:   rd_next = {16'h0, mr_reg[0]};
         `CT16_OFF_MR1:   rd_next = {16'h0, mr_reg[1]};
         `CT16_OFF_MR2:   rd_next = {16'h0, mr_reg[2]};
         `CT16_OFF_MR3:   rd_next = {16'h0, mr_reg[3]};
         `CT16_OFF_CCR:   rd_next = {26'h0, ccr_reg};
         `CT16_OFF_CAP0:  rd_next = {16'h0, cap_reg[0]};
         `CT16_OFF_CAP1:  rd_next = {16'h0, cap_reg[1]};
         `CT16_OFF_EMR:   rd_next = {20'h0, emr_reg};
         `CT16_OFF_COUNT_SOURCE_SELECT:  rd_next = {28'h0, count_source_select_reg};
         `CT16_OFF_PWM:   rd_next = {30'h0, pwm_reg};
         default:         rd_next = `CT16_RST_ZERO;
      endcase
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         {flags_reg, ctl_reg, tc_reg, lim_reg, pc_reg} <= '0;
         {mcr_reg, ccr_reg, emr_reg, count_source_select_reg, pwm_reg} <= '0;
         {rdata_reg, pins_reg, cap_s1, cap_s2, cap_s3} <= '0;
      end else if (ce) begin
         {cap_s1, cap_s2, cap_s3} <= {{capture_input_1, capture_input_0}, cap_s1, cap_s2};
         flags_reg <= flags_next;
         ctl_reg   <= ctl_next;
         tc_reg    <= tc_next;
         pc_reg    <= pc_next;
         emr_reg   <= emr_next;
         pins_reg  <= pins_next;
         rdata_reg <= rd_next;
         if (w_lim) lim_reg <= req.wdata[15:0];
         if (w_mcr) mcr_reg <= req.wdata[11:0];
         if (w_ccr) ccr_reg <= req.wdata[5:0];
         if (w_count_source_select) count_source_select_reg <= req.wdata[3:0];
         if (w_pwm) pwm_reg <= req.wdata[1:0];
      end
   end

   always_ff @(posedge mclk) begin
      for (int i = 0; i < 4; i++) begin
         if (!nrst) mr_reg[i] <= 16'h0000;
         else if (ce && w_mr[i]) mr_reg[i] <= req.wdata[15:0];
      end
      for (int i = 0; i < 2; i++) begin
         if (!nrst) cap_reg[i] <= 16'h0000;
         else if (ce && cap_ev[i]) cap_reg[i] <= tc_reg;
      end
   end

   assign rdata = rdata_reg;
   assign match_output_pins = pins_reg;

   // ****************************************
   // Assertions
   // ****************************************
   a_div_wrap: assert property (
      @(posedge mclk) disable iff (!nrst)
      (ce && term && !clr && !w_pc) |=> (pc_reg == 16'h0000))
      else $error("Divider did not clear at limit");
   a_div_step: assert property (
      @(posedge mclk) disable iff (!nrst)
      (ce && adv && !term && !w_pc && !w_tc) |=>
      (pc_reg == $past(pc_reg) + 16'h0001) && $stable(tc_reg))
      else $error("Divider step wrong");
   a_tc_wrap: assert property (
      @(posedge mclk) disable iff (!nrst)
      (ce && term && tc_reg == 16'hffff && !do_rst && !do_stop && !w_tc)
      |=> (tc_reg == 16'h0000))
      else $error("Timer count did not wrap");
   a_clear_hold: assert property (
      @(posedge mclk) disable iff (!nrst)
      (ce && clr) |=> (tc_reg == 16'h0000) && (pc_reg == 16'h0000))
      else $error("Counters not held clear");
   a_run_off: assert property (
      @(posedge mclk) disable iff (!nrst)
      (!ctl_reg[`CT16_CTL_RUN] && !w_tc && !w_pc && !clr) |=>
      $stable(tc_reg) && $stable(pc_reg))
      else $error("Counters moved while halted");
   a_flag_w1c: assert property (
      @(posedge mclk) disable iff (!nrst)
      (ce && w_flags && fl_set == 6'h00) |=>
      (flags_reg == ($past(flags_reg) & ~$past(req.wdata[5:0]))))
      else $error("Flag clear wrong");
   a_cap_load: assert property (
      @(posedge mclk) disable iff (!nrst)
      (ce && cap_ev[0]) |=> (cap_reg[0] == $past(tc_reg)))
      else $error("Capture did not load count");
   a_match_flag: assert property (
      @(posedge mclk) disable iff (!nrst)
      (ce && match[0] && en_int[0]) |=> flags_reg[0])
      else $error("Match flag not raised");
   a_div_write: assert property (
      @(posedge mclk) disable iff (!nrst)
      (ce && w_pc && !clr) |=> (pc_reg == $past(req.wdata[15:0])))
      else $error("Divider write lost");
   a_pwm_pin: assert property (
      @(posedge mclk) disable iff (!nrst)
      (ce && pwm_reg[0]) |=>
      (match_output_pins[0] == ($past(tc_reg) >= $past(mr_reg[0]))))
      else $error("PWM pin level wrong");
endmodule
`default_nettype wire

// file: inc/ct16_regs.svh
`ifndef CT16_REGS_SVH
`define CT16_REGS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define CT16_OFF_FLAGS 7'h00
`define CT16_OFF_CTL   7'h04
`define CT16_OFF_TC    7'h08
`define CT16_OFF_LIM   7'h0c
`define CT16_OFF_PC    7'h10
`define CT16_OFF_MCR   7'h14
`define CT16_OFF_MR0   7'h18
`define CT16_OFF_MR1   7'h1c
`define CT16_OFF_MR2   7'h20
`define CT16_OFF_MR3   7'h24
`define CT16_OFF_CCR   7'h28
`define CT16_OFF_CAP0  7'h2c
`define CT16_OFF_CAP1  7'h30
`define CT16_OFF_EMR   7'h3c
`define CT16_OFF_COUNT_SOURCE_SELECT  7'h70
`define CT16_OFF_PWM   7'h74
// ****************************************
// Field positions
// ****************************************
`define CT16_CTL_RUN   0
`define CT16_CTL_CLR   1
`define CT16_MCR_INT   0
`define CT16_MCR_RST   1
`define CT16_MCR_STOP  2
`define CT16_CCR_RISE  0
`define CT16_CCR_FALL  1
`define CT16_CCR_INT   2
`define CT16_EMR_ACT   4
`define CT16_COUNT_SOURCE_SELECT_SEL  2
// ****************************************
// Reset values
// ****************************************
`define CT16_RST_ZERO  32'h0000_0000
`endif

// file: inc/ct16_pkg.sv
package ct16_pkg;
   // Register port request, one word per cycle
   typedef struct packed {
      logic        wr;
      logic [6:0]  addr;
      logic [31:0] wdata;
   } ct16_req_t;
   // Count source mode
   typedef enum logic [1:0] {
      CT16_TIMER = 2'h0,
      CT16_RISE  = 2'h1,
      CT16_FALL  = 2'h2,
      CT16_BOTH  = 2'h3
   } ct16_mode_t;
   // Match pin action
   typedef enum logic [1:0] {
      CT16_KEEP   = 2'h0,
      CT16_LOW    = 2'h1,
      CT16_HIGH   = 2'h2,
      CT16_TOGGLE = 2'h3
   } ct16_act_t;
endpackage

// file: verification/ct16_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ct16_regs.svh"
module testbench;
   import ct16_pkg::*;
   // ****************************************
   // Bench signals
   // ****************************************
   logic                mclk;
   logic                nrst;
   logic                ce;
   ct16_req_t           req;
   logic [31:0]         rdata;
   logic                cap0;
   logic                cap1;
   logic [1:0]          pins;
   int                  errors = 0;
   int                  compares = 0;
   int                  cycles = 0;

   ct16_timer dut_u (
      .mclk              (mclk),
      .nrst              (nrst),
      .ce                (ce),
      .req               (req),
      .rdata             (rdata),
      .capture_input_0   (cap0),
      .capture_input_1   (cap1),
      .match_output_pins (pins)
   );

   // ****************************************
   // Tasks and scenarios
   // ****************************************
   task automatic end_of_test;
      $display("Compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Strobe stays up after the taking edge; the next rd or idle lowers it
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      req = '{1'b1, a, d};
      @(posedge mclk);
      #1;
   endtask

   // Read data is registered, so it is looked at just after the sampling edge
   task automatic rd(input logic [6:0] a, input logic [31:0] exp);
      req = '{1'b0, a, 32'h0};
      @(posedge mclk);
      #1 chk(rdata, exp);
   endtask

   task automatic idle(input int n);
      req.wr = 1'b0;
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic sc_reset;
      logic [6:0] offs [17];
      offs = '{`CT16_OFF_FLAGS, `CT16_OFF_CTL, `CT16_OFF_TC, `CT16_OFF_LIM, `CT16_OFF_PC,
               `CT16_OFF_MCR, `CT16_OFF_MR0, `CT16_OFF_MR1, `CT16_OFF_MR2, `CT16_OFF_MR3,
               `CT16_OFF_CCR, `CT16_OFF_CAP0, `CT16_OFF_CAP1, `CT16_OFF_EMR,
               `CT16_OFF_COUNT_SOURCE_SELECT, `CT16_OFF_PWM, 7'h34};
      foreach (offs[i]) rd(offs[i], 32'h0);
   endtask

   task automatic sc_regs;
      for (int i = 0; i < 4; i++) begin
         wr(`CT16_OFF_MR0 + 7'(4 * i), 32'h5a50 + 32'(i));
         rd(`CT16_OFF_MR0 + 7'(4 * i), 32'h5a50 + 32'(i));
      end
      wr(`CT16_OFF_PC, 32'h1234);
      rd(`CT16_OFF_PC, 32'h1234);
   endtask

   // Eight running edges at limit 3 give two steps and cross the wrap
   task automatic sc_count;
      wr(`CT16_OFF_LIM, 32'h3);
      wr(`CT16_OFF_PC, 32'h0);
      wr(`CT16_OFF_TC, 32'hfffe);
      wr(`CT16_OFF_CTL, 32'h1);
      idle(7);
      wr(`CT16_OFF_CTL, 32'h0);
      rd(`CT16_OFF_TC, 32'h0);
      rd(`CT16_OFF_PC, 32'h0);
      rd(`CT16_OFF_FLAGS, 32'h0);
   endtask

   task automatic sc_clear;
      wr(`CT16_OFF_TC, 32'h1234);
      wr(`CT16_OFF_PC, 32'h2);
      wr(`CT16_OFF_CTL, 32'h3);
      wr(`CT16_OFF_TC, 32'h55);
      idle(3);
      rd(`CT16_OFF_TC, 32'h0);
      rd(`CT16_OFF_PC, 32'h0);
      wr(`CT16_OFF_CTL, 32'h0);
      rd(`CT16_OFF_CTL, 32'h0);
   endtask

   task automatic sc_match;
      wr(`CT16_OFF_LIM, 32'h0);
      wr(`CT16_OFF_MR0, 32'h6);
      wr(`CT16_OFF_MCR, 32'h5);
      wr(`CT16_OFF_CTL, 32'h1);
      idle(20);
      rd(`CT16_OFF_TC, 32'h6);
      rd(`CT16_OFF_CTL, 32'h0);
      rd(`CT16_OFF_FLAGS, 32'h1);
      wr(`CT16_OFF_FLAGS, 32'h0);
      rd(`CT16_OFF_FLAGS, 32'h1);
      wr(`CT16_OFF_FLAGS, 32'h1);
      rd(`CT16_OFF_FLAGS, 32'h0);
      // Reset on channel 1 at 3: period 4, so 21 running edges leave 1
      wr(`CT16_OFF_TC, 32'h0);
      wr(`CT16_OFF_MR1, 32'h3);
      wr(`CT16_OFF_MCR, 32'h18);
      wr(`CT16_OFF_CTL, 32'h1);
      idle(20);
      wr(`CT16_OFF_CTL, 32'h0);
      rd(`CT16_OFF_TC, 32'h1);
      rd(`CT16_OFF_FLAGS, 32'h2);
      wr(`CT16_OFF_FLAGS, 32'h3f);
      wr(`CT16_OFF_MCR, 32'h0);
   endtask

   // Channel 0 on rise with flag, channel 1 on fall without flag
   task automatic sc_capture;
      wr(`CT16_OFF_TC, 32'habc);
      wr(`CT16_OFF_CCR, 32'h15);
      cap0 = 1'b1;
      cap1 = 1'b1;
      idle(5);
      rd(`CT16_OFF_CAP0, 32'habc);
      rd(`CT16_OFF_CAP1, 32'h0);
      wr(`CT16_OFF_TC, 32'hdef);
      cap0 = 1'b0;
      cap1 = 1'b0;
      idle(5);
      rd(`CT16_OFF_CAP0, 32'habc);
      rd(`CT16_OFF_CAP1, 32'hdef);
      rd(`CT16_OFF_FLAGS, 32'h10);
      wr(`CT16_OFF_CAP0, 32'h1);
      rd(`CT16_OFF_CAP0, 32'habc);
      wr(`CT16_OFF_FLAGS, 32'h3f);
   endtask

   task automatic sc_counter;
      wr(`CT16_OFF_CCR, 32'h0);
      wr(`CT16_OFF_TC, 32'h0);
      wr(`CT16_OFF_COUNT_SOURCE_SELECT, 32'h1);
      wr(`CT16_OFF_CTL, 32'h1);
      repeat (3) begin
         cap0 = 1'b1;
         idle(4);
         cap0 = 1'b0;
         idle(4);
      end
      wr(`CT16_OFF_CTL, 32'h0);
      rd(`CT16_OFF_TC, 32'h3);
      wr(`CT16_OFF_COUNT_SOURCE_SELECT, 32'h0);
   endtask

   // Ten frozen edges while running, then one live edge
   task automatic sc_freeze;
      wr(`CT16_OFF_TC, 32'h0);
      wr(`CT16_OFF_CTL, 32'h1);
      ce = 1'b0;
      idle(10);
      ce = 1'b1;
      wr(`CT16_OFF_CTL, 32'h0);
      rd(`CT16_OFF_TC, 32'h1);
   endtask

   task automatic sc_pins;
      wr(`CT16_OFF_EMR, 32'h20);
      wr(`CT16_OFF_TC, 32'h0);
      wr(`CT16_OFF_MR0, 32'h2);
      wr(`CT16_OFF_CTL, 32'h1);
      idle(8);
      wr(`CT16_OFF_CTL, 32'h0);
      chk({30'h0, pins}, 32'h1);
      rd(`CT16_OFF_EMR, 32'h21);
      // Held state bit is 1, so a low pin proves the pulse mode drives it
      wr(`CT16_OFF_PWM, 32'h1);
      wr(`CT16_OFF_MR0, 32'h10);
      wr(`CT16_OFF_TC, 32'h20);
      idle(2);
      chk({30'h0, pins}, 32'h1);
      wr(`CT16_OFF_TC, 32'h5);
      idle(2);
      chk({30'h0, pins}, 32'h0);
   endtask

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // A full run takes a few hundred cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 3000) begin
         errors++;
         $display("BAD at %0t: timeout", $time);
         end_of_test;
      end
   end

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      req = '0;
      cap0 = 1'b0;
      cap1 = 1'b0;
      repeat (4) @(posedge mclk);
      #1 nrst = 1'b1;
      sc_reset;
      sc_regs;
      sc_count;
      sc_clear;
      sc_match;
      sc_capture;
      sc_counter;
      sc_pins;
      sc_freeze;
      end_of_test;
   end
endmodule
`default_nettype wire
